// ---- shared/rmc_regs.svh ----
// register indices, field positions, reset values of the modem config bank
`ifndef RMC_REGS_SVH
`define RMC_REGS_SVH
// register indices; byte address is four times the index
`define RMC_IDX_CODING    16'hDF0F
`define RMC_IDX_MANTISSA  16'hDF10
`define RMC_IDX_DEVIATION 16'hDF11
// coding/preamble register fields
`define RMC_FEC_BIT       7
`define RMC_PRE_HI        6
`define RMC_PRE_LO        4
`define RMC_SPE_HI        1
`define RMC_SPE_LO        0
// deviation register fields
`define RMC_DEVE_HI       6
`define RMC_DEVE_LO       4
// reset values
`define RMC_RST_FEC       1'h0
`define RMC_RST_PRE       3'h2
`define RMC_RST_SPE       2'h2
`define RMC_RST_MANT      8'hF8
`define RMC_RST_DEVE      3'h4
// implied leading terms of the mantissas
`define RMC_SPC_OFFSET    12'h100
`define RMC_DEV_OFFSET    11'h008
`endif

// ---- shared/rmc_pkg.sv ----
// types shared by the modem configuration register bank
package rmc_pkg;
    typedef enum logic [1:0]
    {
        RMC_SEL_NONE = 2'b00,
        RMC_SEL_CODE = 2'b01,
        RMC_SEL_MANT = 2'b10,
        RMC_SEL_DEV  = 2'b11
    } rmc_sel_type;
endpackage

// ---- core/rmc_config_regs.sv ----
// modem configuration register bank on an AHB-Lite slave port
`timescale 1ns/1ps
`include "rmc_regs.svh"

// Behaviour
// - bit 7 enables payload error correction
// - bits 6:4 select minimum preamble bytes
// - eight-bit spacing mantissa, reset F8
// - spacing is (256+mantissa) shifted by exponent
// - target is base plus spacing times channel
// - deviation is (8+mantissa) shifted by exponent
module rmc_config_regs #(
    parameter int FREQ_W = 32
)(
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // packet and synthesiser context
    input  wire logic              length_mode_fixed,
    input  wire logic [7:0]        hop_index,
    input  wire logic [FREQ_W-1:0] base_freq,
    input  wire logic [2:0]        deviation_mantissa,
    // configuration to the modem
    output logic                   error_correction_enable,
    output logic                   error_correction_active,
    output logic      [4:0]        preamble_bytes,
    output logic      [7:0]        spacing_mantissa,
    output logic      [1:0]        spacing_exponent,
    output logic      [11:0]       spacing_step,
    output logic      [FREQ_W-1:0] target_freq,
    output logic      [2:0]        deviation_exponent,
    output logic      [10:0]       deviation_step
);

    initial
    begin
        if (FREQ_W < 21)
            $error("FREQ_W too narrow for base plus channel offset");
    end

    // ****************************************************
    // functions
    // ****************************************************
    function automatic logic [4:0] preamble_count(input logic [2:0] code);
        logic [4:0] n;
        n = 5'h02;
        unique case (code)
            3'h0: n = 5'h02;
            3'h1: n = 5'h03;
            3'h2: n = 5'h04;
            3'h3: n = 5'h06;
            3'h4: n = 5'h08;
            3'h5: n = 5'h0C;
            3'h6: n = 5'h10;
            3'h7: n = 5'h18;
        endcase
        return n;
    endfunction

    function automatic logic [11:0] spc_step(input logic [7:0] m,
                                             input logic [1:0] e);
        logic [11:0] base;
        base = `RMC_SPC_OFFSET + {4'h0, m};
        return 12'(base << e);
    endfunction

    function automatic logic [10:0] dev_step(input logic [2:0] m,
                                             input logic [2:0] e);
        logic [10:0] base;
        base = `RMC_DEV_OFFSET + {8'h00, m};
        return 11'(base << e);
    endfunction

    function automatic rmc_pkg::rmc_sel_type decode(input logic [31:0] a);
        rmc_pkg::rmc_sel_type s;
        s = rmc_pkg::RMC_SEL_NONE;
        if (a[1:0] == 2'h0)
        begin
            if (a[31:2] == {14'h0000, `RMC_IDX_CODING})
                s = rmc_pkg::RMC_SEL_CODE;
            else if (a[31:2] == {14'h0000, `RMC_IDX_MANTISSA})
                s = rmc_pkg::RMC_SEL_MANT;
            else if (a[31:2] == {14'h0000, `RMC_IDX_DEVIATION})
                s = rmc_pkg::RMC_SEL_DEV;
        end
        return s;
    endfunction

    // ****************************************************
    // bus address phase capture
    // ****************************************************
    rmc_pkg::rmc_sel_type sel_ff;
    logic                 wr_ff;
    logic                 rd_ff;
    logic                 take;

    // zero wait states: every transfer completes in its first data cycle
    assign take      = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_ff <= rmc_pkg::RMC_SEL_NONE;
            wr_ff  <= 1'b0;
            rd_ff  <= 1'b0;
        end
        else if (hready)
        begin
            sel_ff <= take ? decode(haddr) : rmc_pkg::RMC_SEL_NONE;
            wr_ff  <= take && hwrite;
            rd_ff  <= take && !hwrite;
        end
    end

    // ****************************************************
    // register storage
    // ****************************************************
    logic       fec_ff;
    logic [2:0] pre_ff;
    logic [1:0] spe_ff;
    logic [7:0] mant_ff;
    logic [2:0] deve_ff;
    logic       wr_code;
    logic       wr_mant;
    logic       wr_dev;

    assign wr_code = wr_ff && (sel_ff == rmc_pkg::RMC_SEL_CODE);
    assign wr_mant = wr_ff && (sel_ff == rmc_pkg::RMC_SEL_MANT);
    assign wr_dev  = wr_ff && (sel_ff == rmc_pkg::RMC_SEL_DEV);

    // unused bits are not stored at all
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fec_ff <= `RMC_RST_FEC;
            pre_ff <= `RMC_RST_PRE;
            spe_ff <= `RMC_RST_SPE;
        end
        else if (wr_code)
        begin
            fec_ff <= hwdata[`RMC_FEC_BIT];
            pre_ff <= hwdata[`RMC_PRE_HI:`RMC_PRE_LO];
            spe_ff <= hwdata[`RMC_SPE_HI:`RMC_SPE_LO];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mant_ff <= `RMC_RST_MANT;
        else if (wr_mant)
            mant_ff <= hwdata[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            deve_ff <= `RMC_RST_DEVE;
        else if (wr_dev)
            deve_ff <= hwdata[`RMC_DEVE_HI:`RMC_DEVE_LO];
    end

    // ****************************************************
    // read data
    // ****************************************************
    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (rd_ff)
        begin
            unique case (sel_ff)
                rmc_pkg::RMC_SEL_CODE:
                    hrdata = {24'h0, fec_ff, pre_ff, 2'h0, spe_ff};
                rmc_pkg::RMC_SEL_MANT:
                    hrdata = {24'h0, mant_ff};
                rmc_pkg::RMC_SEL_DEV:
                    hrdata = {24'h0, 1'b0, deve_ff, 4'h0};
                rmc_pkg::RMC_SEL_NONE:
                    hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************
    // derived configuration
    // ****************************************************
    logic [FREQ_W-1:0] offset;

    assign error_correction_enable = fec_ff;
    assign spacing_mantissa        = mant_ff;
    assign spacing_exponent        = spe_ff;
    assign deviation_exponent      = deve_ff;
    assign offset = FREQ_W'(spacing_step) * FREQ_W'(hop_index);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            error_correction_active <= 1'b0;
        else
            error_correction_active <= fec_ff && length_mode_fixed;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            preamble_bytes <= 5'h04;
        else
            preamble_bytes <= preamble_count(pre_ff);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            spacing_step <= 12'h000;
        else
            spacing_step <= spc_step(mant_ff, spe_ff);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            target_freq <= '0;
        else
            target_freq <= FREQ_W'(base_freq + offset);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            deviation_step <= 11'h000;
        else
            deviation_step <= dev_step(deviation_mantissa, deve_ff);
    end

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence code_write_s;
        hsel && hready && htrans[1] && hwrite &&
        decode(haddr) == rmc_pkg::RMC_SEL_CODE;
    endsequence

    sequence mant_write_s;
        hsel && hready && htrans[1] && hwrite &&
        decode(haddr) == rmc_pkg::RMC_SEL_MANT;
    endsequence

    sequence read_s(rmc_pkg::rmc_sel_type s);
        hsel && hready && htrans[1] && !hwrite && decode(haddr) == s;
    endsequence

    fec_write_a: assert property (
        code_write_s ##1 1'b1 |=>
        error_correction_enable == $past(hwdata[7]))
        else $error("fec enable did not follow write");

    fec_gate_a: assert property (
        ##1 error_correction_active ==
        ($past(error_correction_enable) && $past(length_mode_fixed)))
        else $error("fec active not gated by fixed length");

    preamble_map_a: assert property (
        code_write_s ##1 (hwdata[6:4] == 3'h7) ##1 1'b1 |=>
        preamble_bytes == 5'h18)
        else $error("preamble code 7 not 24 bytes");

    mant_write_a: assert property (
        mant_write_s ##1 1'b1 |=> spacing_mantissa == $past(hwdata[7:0]))
        else $error("spacing mantissa did not follow write");

    spacing_calc_a: assert property (
        $stable(spacing_mantissa) && $stable(spacing_exponent) |=>
        spacing_step == 12'((12'h100 + {4'h0, $past(spacing_mantissa)})
                            << $past(spacing_exponent)))
        else $error("spacing step wrong");

    target_calc_a: assert property (
        ##1 target_freq == FREQ_W'($past(base_freq) +
        $past(spacing_step) * $past(hop_index)))
        else $error("target frequency wrong");

    deviation_calc_a: assert property (
        $stable(deviation_exponent) && $stable(deviation_mantissa) |=>
        deviation_step == 11'((11'h008 + {8'h00, $past(deviation_mantissa)})
                              << $past(deviation_exponent)))
        else $error("deviation step wrong");

    code_unused_a: assert property (
        read_s(rmc_pkg::RMC_SEL_CODE) |=> hrdata[31:8] == 24'h0 &&
        hrdata[3:2] == 2'h0)
        else $error("coding register unused bits not zero");

    dev_unused_a: assert property (
        read_s(rmc_pkg::RMC_SEL_DEV) |=> hrdata[7] == 1'b0 &&
        hrdata[3:0] == 4'h0)
        else $error("deviation register unused bits not zero");

endmodule

// ---- verif/test_rmc_config_regs.sv ----
// self-checking bench for the modem configuration register bank
`timescale 1ns/1ps
`include "rmc_regs.svh"

module test_rmc_config_regs;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, tf, base;
    logic [1:0]  htrans, sexp;
    logic [2:0]  hsize, dm, dexp;
    logic        lmf, ecc_en, ecc_act;
    logic [7:0]  hop, smant, sc, sm, sd;
    logic [4:0]  pb;
    logic [11:0] step;
    logic [10:0] dstep;
    int          miscompares, check_count;

    assign hready = hreadyout;

    rmc_config_regs #(.FREQ_W(32)) u_rmc_config_regs (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .length_mode_fixed(lmf), .hop_index(hop),
        .base_freq(base), .deviation_mantissa(dm),
        .error_correction_enable(ecc_en), .error_correction_active(ecc_act),
        .preamble_bytes(pb), .spacing_mantissa(smant),
        .spacing_exponent(sexp), .spacing_step(step), .target_freq(tf),
        .deviation_exponent(dexp), .deviation_step(dstep));

    // ****************************************************************
    // helpers
    // ****************************************************************
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    function automatic logic [31:0] ad(input logic [15:0] i);
        return {14'h0, i, 2'b00};
    endfunction

    function automatic logic [4:0] pre_exp(input logic [2:0] c);
        logic [4:0] t [8] = '{5'h02, 5'h03, 5'h04, 5'h06,
                              5'h08, 5'h0C, 5'h10, 5'h18};
        return t[c];
    endfunction

    function automatic logic [11:0] sstep(input logic [7:0] m,
                                          input logic [1:0] e);
        return (12'h100 + {4'h0, m}) << e;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one single ahb-lite transfer; waits for hready in both phases
    task automatic xfer(input logic w, input logic [31:0] a, wd,
                        output logic [31:0] rd);
        int n;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= wd;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        rd = hrdata;
        chk("hresp", hresp, 32'h0);
    endtask

    task automatic check_all;
        logic [31:0] r;
        xfer(1'b0, ad(`RMC_IDX_CODING), 32'h0, r);
        chk("coding", r, {24'h0, sc});
        xfer(1'b0, ad(`RMC_IDX_MANTISSA), 32'h0, r);
        chk("mantissa", r, {24'h0, sm});
        xfer(1'b0, ad(`RMC_IDX_DEVIATION), 32'h0, r);
        chk("deviation", r, {24'h0, sd});
        repeat (2) @(posedge hclk);
        #1;
        chk("error_correction_enable", ecc_en, sc[7]);
        chk("fec_act", ecc_act, sc[7] & lmf);
        chk("preamble", pb, pre_exp(sc[6:4]));
        chk("sp_mant", smant, sm);
        chk("sp_exp", sexp, sc[1:0]);
        chk("sp_step", step, sstep(sm, sc[1:0]));
        chk("target", tf, base + sstep(sm, sc[1:0]) * hop);
        chk("dev_exp", dexp, sd[6:4]);
        chk("dev_step", dstep, (11'h008 + dm) << sd[6:4]);
    endtask

    task end_of_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        end_of_test;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        logic [31:0] r, d;
        {hresetn, hsel, hwrite, htrans, hsize} = '0;
        {haddr, hwdata, base, hop, dm} = '0;
        lmf = 1'b1;
        miscompares = 0;
        check_count = 0;
        sc = 8'h22;
        sm = 8'hF8;
        sd = 8'h40;
        void'($urandom(32'h105C));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        check_all;
        // every preamble code, unused bits 3:2 written high
        for (int c = 0; c < 8; c++)
        begin
            d = {24'h0, 1'b0, c[2:0], 4'hD};
            xfer(1'b1, ad(`RMC_IDX_CODING), d, r);
            sc = d[7:0] & 8'hF3;
            check_all;
        end
        for (int i = 0; i < 30; i++)
        begin
            d = $urandom;
            // coding only enabled with fixed length
            lmf  <= d[7] | d[8];
            hop  <= 8'($urandom);
            base <= $urandom;
            dm   <= 3'($urandom);
            xfer(1'b1, ad(`RMC_IDX_CODING), d, r);
            sc = d[7:0] & 8'hF3;
            d = $urandom;
            xfer(1'b1, ad(`RMC_IDX_MANTISSA), d, r);
            sm = d[7:0];
            d = $urandom;
            xfer(1'b1, ad(`RMC_IDX_DEVIATION), d, r);
            sd = d[7:0] & 8'h70;
            check_all;
        end
        // unmapped places ignore writes and read zero
        xfer(1'b1, ad(16'hDF12), 32'hFFFF_FFFF, r);
        xfer(1'b1, 32'h8000_0000 | ad(`RMC_IDX_CODING), 32'hFF, r);
        xfer(1'b0, ad(16'hDF12), 32'h0, r);
        chk("unmapped", r, 32'h0);
        xfer(1'b0, 32'h8000_0000 | ad(`RMC_IDX_CODING), 32'h0, r);
        chk("high_addr", r, 32'h0);
        check_all;
        end_of_test;
    end
endmodule
